//--- asc_pkg.sv
// Package: register map, field positions and types of the shared-core control
package asc_pkg;
  localparam logic [7:0] ADDR_TIMING_IRQ = 8'h00;
  localparam logic [7:0] ADDR_REF_SAMPLE = 8'h04;
  localparam logic [7:0] ADDR_TRIG_SUSP  = 8'h08;
  localparam logic [7:0] ADDR_MODULE     = 8'h0c;
  localparam logic [7:0] ADDR_EVENTS     = 8'h10;
  // Timing/irq register fields
  localparam int B_REF_READY_IRQ_EN = 15;
  localparam int B_REF_ERROR_IRQ_EN = 14;
  localparam int B_EARLY_IRQ_EN     = 12;
  localparam int B_EXT_SEQ_REQ_EN   = 11;
  localparam int B_EARLY_SEL_LO     = 8;
  localparam int B_CLK_DIV_LO       = 0;
  localparam logic [15:0] MASK_TIMING_IRQ = 16'hdf7f;
  // Reference status / sample time fields
  localparam int B_REF_READY_FLAG   = 15;
  localparam int B_REF_ERROR_FLAG   = 14;
  localparam logic [15:0] MASK_SAMPLE = 16'h03ff;
  // Trigger/suspend register fields
  localparam int B_REF_SEL_LO       = 13;
  localparam int B_SUSPEND          = 12;
  localparam int B_SUSPEND_IRQ_EN   = 11;
  localparam int B_SUSPENDED_FLAG   = 10;
  localparam int B_SW_SAMPLE        = 9;
  localparam int B_SW_CH_TRIG       = 8;
  localparam int B_SW_LEVEL_TRIG    = 7;
  localparam int B_SW_COMMON_TRIG   = 6;
  localparam logic [15:0] MASK_TRIG_SUSP = 16'hfbff;
  // Module register: converter_on bit 15, shared_resolution bits 6:5
  localparam int B_CONVERTER_ON     = 15;
  localparam int B_RES_LO           = 5;
  localparam logic [15:0] MASK_MODULE = 16'h8060;
  localparam logic [1:0]  RES_RESET   = 2'h3;
  // Sticky common-event status, write one to clear
  localparam int E_REF_READY = 0;
  localparam int E_REF_ERROR = 1;
  localparam int E_SUSPENDED = 2;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef struct packed {
    logic       ready_irq_en;
    logic       error_irq_en;
    logic       early_irq_en;
    logic       ext_req_en;
    logic [2:0] early_sel;
    logic [6:0] clk_div;
  } asc_timing_s;

  typedef struct packed {
    logic       level;
    logic       common;
    logic       channel;
    logic [5:0] chan;
  } asc_trig_s;
endpackage : asc_pkg

//--- asc_ctrl.sv
// Shared-core clock, sample timing, early interrupt and software triggers
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Contract
// RL1 - Ready enable routes band gap ready to irq
// RL2 - Error enable routes reference error to irq
// RL3 - Early enable picks early or ready channel irq
// RL4 - External sequencer requests pass only when enabled
// RL5 - Early flag N+1 core clocks before ready
// RL6 - Software avoids invalid early select codes
// RL7 - Core clock lasts 2N source clocks, min 2
// RL8 - Ready flag follows band gap, read only
// RL9 - Error flag sets when band gap lost while on
// RL10 - Sample time is N+2 core clocks
// RL11 - Software writes only reference select zero
// RL12 - Suspend blocks every new trigger
// RL13 - Suspended flag when suspend and cores idle
// RL14 - Suspend enable raises irq on suspended flag
// RL15 - Software sampling connects selected channel
// RL16 - Channel trigger pulses once, self clears
// RL17 - Level trigger repeats while set
// RL18 - Common trigger pulses once, self clears
// RL19 - Channel field picks trigger and sample input
// RL20 - Unimplemented bits ignore writes, read zero
// RL21 - Resolution codes 11,10,01,00 give 12,10,8,6
// RL22 - Converter on bit enables module
// RL23 - Writes act next edge, flags synchronised
module asc_ctrl (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        band_gap_ready,
  input  wire logic        ref_fault,
  input  wire logic        cores_busy,
  input  wire logic        seq_request,
  input  wire logic        channel_result_ready,
  input  wire logic        early_status_flag,
  output logic             core_clk_tick,
  output logic             sampling,
  output logic             conv_start,
  output logic             early_flag_out,
  output logic             channel_irq,
  output logic             common_irq,
  output logic             converter_on,
  output logic      [1:0]  shared_resolution,
  output logic      [2:0]  ref_select,
  output logic             seq_trigger,
  output logic             sw_sample_ctrl,
  output logic             sw_chan_trig_pulse,
  output logic             sw_common_trig_pulse,
  output logic             sw_level_trig,
  output logic      [5:0]  sw_trigger_channel
);
  logic [15:0] timing_reg;
  logic [9:0]  shared_sample_time;
  logic [15:0] trig_reg;
  logic [2:0]  events;
  logic [2:0]  ready_sync;
  logic [2:0]  fault_sync;
  logic [2:0]  busy_sync;
  logic        ref_ready_flag;
  logic        ref_error_flag;
  logic        suspended_flag;
  logic        suspended_q;
  logic        ready_q;
  logic [7:0]  src_cnt;
  logic [10:0] samp_cnt;
  logic [3:0]  conv_cnt;
  logic        converting;

  asc_pkg::asc_timing_s tcfg;
  asc_pkg::asc_trig_s   tsw;
  assign tcfg = asc_pkg::asc_timing_s'({timing_reg[15:14], timing_reg[12:8],
                                        timing_reg[6:0]});
  // Field order of the struct differs from the register bit order
  assign tsw  = asc_pkg::asc_trig_s'({trig_reg[asc_pkg::B_SW_LEVEL_TRIG],
                                      trig_reg[asc_pkg::B_SW_COMMON_TRIG],
                                      trig_reg[asc_pkg::B_SW_CH_TRIG],
                                      trig_reg[5:0]});

  wire wr_en   = psel && penable && pwrite;
  wire a_tim   = paddr == asc_pkg::ADDR_TIMING_IRQ;
  wire a_samp  = paddr == asc_pkg::ADDR_REF_SAMPLE;
  wire a_trig  = paddr == asc_pkg::ADDR_TRIG_SUSP;
  wire a_mod   = paddr == asc_pkg::ADDR_MODULE;
  wire a_evt   = paddr == asc_pkg::ADDR_EVENTS;
  wire a_ok    = a_tim | a_samp | a_trig | a_mod | a_evt;
  wire suspend = trig_reg[asc_pkg::B_SUSPEND];

  // Divider: half period is max(N,1) source clocks, so N=0 equals N=1
  wire [7:0] div_half = (tcfg.clk_div == 7'h00) ? 8'h01 : {1'b0, tcfg.clk_div};
  wire [7:0] div_full = 8'(div_half << 1);
  wire       tick     = src_cnt == 8'(div_full - 8'h01); // RL7

  // Conversion length in core clocks by resolution, 6..12 bits
  function automatic logic [3:0] conv_len(input logic [1:0] res);
    conv_len = 4'(4'h6 + {1'b0, res, 1'b0}); // RL21
  endfunction
  wire [3:0] early_at = 4'(tcfg.early_sel) + 4'h1; // RL5

  wire sw_trig_any = tsw.channel | tsw.common | tsw.level;
  wire ext_trig    = seq_request & tcfg.ext_req_en; // RL4
  wire new_trig    = (sw_trig_any | ext_trig) & ~suspend
                     & converter_on & ~converting & ~(|samp_cnt); // RL12

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ready_sync <= 3'h0;
      fault_sync <= 3'h0;
      busy_sync  <= 3'h0;
    end else begin
      ready_sync <= {ready_sync[1:0], band_gap_ready}; // RL23
      fault_sync <= {fault_sync[1:0], ref_fault};
      busy_sync  <= {busy_sync[1:0], cores_busy};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_ready_flag <= 1'b0;
      ref_error_flag <= 1'b0;
      suspended_flag <= 1'b0;
    end else begin
      if (ready_sync[2] == ready_sync[1])
        ref_ready_flag <= ready_sync[2]; // RL8
      if (!converter_on)
        ref_error_flag <= 1'b0;
      else if ((fault_sync[2] & fault_sync[1]) |
               (ready_q & ~ready_sync[2] & ~ready_sync[1]))
        ref_error_flag <= 1'b1; // RL9 RL22
      suspended_flag <= suspend & ~converting & ~(|samp_cnt)
                        & ~busy_sync[2] & ~busy_sync[1]; // RL13
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ready_q     <= 1'b0;
      suspended_q <= 1'b0;
    end else begin
      ready_q     <= ref_ready_flag;
      suspended_q <= suspended_flag;
    end
  end

  wire ev_ready = ref_ready_flag & ~ready_q;
  wire ev_susp  = suspended_flag & ~suspended_q;
  logic err_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      err_q <= 1'b0;
    else
      err_q <= ref_error_flag;
  end
  wire ev_err_rise = ref_error_flag & ~err_q;
  wire [2:0] ev_set = {ev_susp, ev_err_rise, ev_ready};
  wire [2:0] ev_clr = (wr_en && a_evt) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      events <= 3'h0;
    else
      events <= (events & ~ev_clr) | ev_set;
  end

  // Registers; hardware clears one-shot triggers one cycle after the write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timing_reg         <= asc_pkg::RESET_WORD;
      shared_sample_time <= 10'h000;
      trig_reg           <= asc_pkg::RESET_WORD;
      converter_on       <= 1'b0;
      shared_resolution  <= asc_pkg::RES_RESET;
    end else begin
      if (wr_en && a_tim)
        timing_reg <= pwdata[15:0] & asc_pkg::MASK_TIMING_IRQ; // RL20 RL23
      if (wr_en && a_samp)
        shared_sample_time <= pwdata[9:0];
      if (wr_en && a_trig)
        trig_reg <= pwdata[15:0] & asc_pkg::MASK_TRIG_SUSP; // RL20
      else begin
        trig_reg[asc_pkg::B_SW_CH_TRIG]     <= 1'b0; // RL16
        trig_reg[asc_pkg::B_SW_COMMON_TRIG] <= 1'b0; // RL18
      end
      if (wr_en && a_mod) begin
        converter_on      <= pwdata[asc_pkg::B_CONVERTER_ON]; // RL22
        shared_resolution <= pwdata[asc_pkg::B_RES_LO +: 2];
      end
    end
  end

  // Core clock, sample and conversion timing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_cnt    <= 8'h00;
      samp_cnt   <= 11'h000;
      conv_cnt   <= 4'h0;
      converting <= 1'b0;
    end else begin
      src_cnt <= (tick || !converter_on) ? 8'h00 : 8'(src_cnt + 8'h01);
      if (new_trig)
        samp_cnt <= 11'(shared_sample_time) + 11'h002; // RL10
      else if (tick && samp_cnt != 11'h000) begin
        samp_cnt <= 11'(samp_cnt - 11'h001);
        if (samp_cnt == 11'h001 && !trig_reg[asc_pkg::B_SW_SAMPLE]) begin
          converting <= 1'b1;
          conv_cnt   <= conv_len(shared_resolution);
        end
      end else if (tick && converting) begin
        conv_cnt <= 4'(conv_cnt - 4'h1);
        if (conv_cnt == 4'h1)
          converting <= 1'b0;
      end
    end
  end

  wire hold_sample = trig_reg[asc_pkg::B_SW_SAMPLE] && samp_cnt == 11'h001;

  // Registered outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_clk_tick        <= 1'b0;
      sampling             <= 1'b0;
      conv_start           <= 1'b0;
      early_flag_out       <= 1'b0;
      channel_irq          <= 1'b0;
      common_irq           <= 1'b0;
      ref_select           <= 3'h0;
      seq_trigger          <= 1'b0;
      sw_sample_ctrl       <= 1'b0;
      sw_chan_trig_pulse   <= 1'b0;
      sw_common_trig_pulse <= 1'b0;
      sw_level_trig        <= 1'b0;
      sw_trigger_channel   <= 6'h00;
    end else begin
      core_clk_tick  <= tick;
      sampling       <= (samp_cnt != 11'h000) | trig_reg[asc_pkg::B_SW_SAMPLE]; // RL15
      conv_start     <= tick && samp_cnt == 11'h001 && !hold_sample;
      early_flag_out <= converting && tick && conv_cnt == early_at; // RL5
      channel_irq    <= tcfg.early_irq_en ? early_status_flag
                                          : channel_result_ready; // RL3
      common_irq     <= |(events & {trig_reg[asc_pkg::B_SUSPEND_IRQ_EN],
                                    tcfg.error_irq_en,
                                    tcfg.ready_irq_en}); // RL1 RL2 RL14
      ref_select     <= trig_reg[asc_pkg::B_REF_SEL_LO +: 3];
      seq_trigger    <= ext_trig & ~suspend;
      sw_sample_ctrl <= trig_reg[asc_pkg::B_SW_SAMPLE];
      sw_chan_trig_pulse   <= tsw.channel & ~suspend;
      sw_common_trig_pulse <= trig_reg[asc_pkg::B_SW_COMMON_TRIG] & ~suspend; // RL18
      sw_level_trig        <= tsw.level & ~suspend; // RL17
      sw_trigger_channel   <= tsw.chan; // RL19
    end
  end

  // APB read path, zero wait states
  wire [15:0] rd_samp = {ref_ready_flag, ref_error_flag, 4'h0,
                         shared_sample_time};
  wire [15:0] rd_trig = (trig_reg & asc_pkg::MASK_TRIG_SUSP) |
                        (16'(suspended_flag) << asc_pkg::B_SUSPENDED_FLAG);
  wire [15:0] rd_mod  = {converter_on, 8'h00, shared_resolution, 5'h00};
  wire [15:0] rd_word = a_tim  ? timing_reg :
                        a_samp ? rd_samp :
                        a_trig ? rd_trig :
                        a_mod  ? rd_mod :
                        a_evt  ? {13'h0000, events} : 16'h0000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~a_ok;
      prdata  <= (psel & ~penable & ~pwrite) ? {16'h0000, rd_word} : 32'h0;
    end
  end
endmodule // asc_ctrl
`default_nettype wire

//--- asc_ctrl_assertions.sv
// Port checker for the shared-core control block
`timescale 1ns/100ps
`default_nettype none
module asc_ctrl_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        early_status_flag,
  input wire logic        channel_result_ready,
  input wire logic        channel_irq,
  input wire logic        seq_request,
  input wire logic        seq_trigger,
  input wire logic        core_clk_tick,
  input wire logic        sw_chan_trig_pulse,
  input wire logic        sw_common_trig_pulse,
  input wire logic        sw_level_trig,
  input wire logic [5:0]  sw_trigger_channel
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic       wr_trig;
  logic [1:0] wr_ch;
  logic [1:0] wr_cm;
  assign wr_trig = psel && penable && pwrite && paddr == 8'h08;
  // Recent trigger writes, a pulse must trace back to one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ch <= 2'h0;
      wr_cm <= 2'h0;
    end else begin
      wr_ch <= {wr_ch[0], wr_trig && pwdata[8]};
      wr_cm <= {wr_cm[0], wr_trig && pwdata[6]};
    end
  end
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("ready held");
  property p_unimpl; pready && !pwrite && paddr == 8'h00
    |-> prdata[31:16] == 16'h0 && !prdata[13] && !prdata[7]; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimpl bit");
  property p_refused; pready && pslverr
    |-> paddr > 8'h10 && (pwrite || prdata == 32'h0); endproperty
  a_refused: assert property (p_refused) else $error("bad refuse");
  property p_chan; sw_chan_trig_pulse
    |-> wr_ch != 2'h0 ##1 !sw_chan_trig_pulse; endproperty
  a_chan: assert property (p_chan) else $error("chan pulse");
  property p_comm; sw_common_trig_pulse
    |-> wr_cm != 2'h0 ##1 !sw_common_trig_pulse; endproperty
  a_comm: assert property (p_comm) else $error("common pulse");
  property p_mirror; wr_trig |-> ##2 sw_level_trig == $past(pwdata[7], 2)
    && sw_trigger_channel == $past(pwdata[5:0], 2); endproperty
  a_mirror: assert property (p_mirror) else $error("mirror");
  property p_chirq; early_status_flag == channel_result_ready
    |=> channel_irq == $past(early_status_flag); endproperty
  a_chirq: assert property (p_chirq) else $error("chan irq");
  property p_seq; seq_trigger |-> $past(seq_request); endproperty
  a_seq: assert property (p_seq) else $error("seq trig");
  property p_tick; core_clk_tick |=> !core_clk_tick; endproperty
  a_tick: assert property (p_tick) else $error("tick");
  c_chan: cover property (sw_chan_trig_pulse);
  c_err: cover property (pready && pslverr);
  c_seq: cover property (seq_trigger);
endmodule // asc_ctrl_chk
bind asc_ctrl asc_ctrl_chk i_chk (.clock, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .early_status_flag,
  .channel_result_ready, .channel_irq, .seq_request, .seq_trigger,
  .core_clk_tick, .sw_chan_trig_pulse, .sw_common_trig_pulse,
  .sw_level_trig, .sw_trigger_channel);
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench for the shared-core control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        band_gap_ready, ref_fault, cores_busy, seq_request;
  logic        channel_result_ready, early_status_flag, core_clk_tick;
  logic        sampling, conv_start, early_flag_out, channel_irq;
  logic        common_irq, converter_on, seq_trigger, sw_sample_ctrl;
  logic        sw_chan_trig_pulse, sw_common_trig_pulse, sw_level_trig;
  logic [1:0]  shared_resolution;
  logic [2:0]  ref_select;
  logic [5:0]  sw_trigger_channel;
  logic [15:0] mdl [0:4];
  int          n_mismatch, samples_checked, cyc, n_ch, n_cm, n_sq, n, d;
  int          dv [4] = '{0, 1, 3, 9};
  asc_ctrl i_asc_ctrl (.clock, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .band_gap_ready, .ref_fault,
    .cores_busy, .seq_request, .channel_result_ready, .early_status_flag,
    .core_clk_tick, .sampling, .conv_start, .early_flag_out, .channel_irq,
    .common_irq, .converter_on, .shared_resolution, .ref_select,
    .seq_trigger, .sw_sample_ctrl, .sw_chan_trig_pulse,
    .sw_common_trig_pulse, .sw_level_trig, .sw_trigger_channel);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) {early_status_flag, channel_result_ready} <= 2'($urandom);
  // Counting on the falling edge keeps it clear of the driving edge
  always @(negedge clock) begin
    cyc++;
    n_ch += int'(sw_chan_trig_pulse === 1'b1);
    n_cm += int'(sw_common_trig_pulse === 1'b1);
    n_sq += int'(seq_trigger === 1'b1);
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test;
    end
  end
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task wr(input logic [7:0] a, input logic [15:0] dt);
    apb(1'b1, a, {16'h0, dt});
    if (a == 8'h00) mdl[0] = dt & 16'hdf7f;
    if (a == 8'h04) mdl[1] = dt & 16'h03ff;
    if (a == 8'h08) mdl[2] = dt & 16'hfabf;
    if (a == 8'h0c) mdl[3] = dt & 16'h8060;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] fl);
    apb(1'b0, a, 32'h0);
    chk("rdata", r, {16'h0, mdl[a[4:2]] | fl});
  endtask
  initial begin
    void'($urandom(52153));
    rst = 1'b1;
    {psel, penable, pwrite, band_gap_ready, ref_fault, cores_busy} = '0;
    {seq_request, channel_result_ready, early_status_flag} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mdl = '{default: 16'h0};
    mdl[3] = 16'h0060;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("res", shared_resolution, 2'h3);
    for (int a = 0; a < 20; a += 4) rd(8'(a), 16'h0);
    for (int i = 0; i < 12; i++) begin
      d = $urandom;
      n = (i % 4) * 4;
      if (n == 8) d = d & 32'h0fff;
      if (n == 0) d = d & 32'hfbff;
      wr(8'(n), d[15:0]);
      rd(8'(n), 16'h0);
      chk("mirror", {converter_on, shared_resolution, sw_sample_ctrl,
        sw_level_trig, sw_trigger_channel, ref_select}, {mdl[3][15],
        mdl[3][6:5], mdl[2][9], mdl[2][7], mdl[2][5:0], mdl[2][15:13]});
    end
    wr(8'h14, 16'hffff);
    chk("wr_err", err, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    chk("rd_err", {err, r}, {1'b1, 32'h0});
    wr(8'h0c, 16'h8060);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, 16'(dv[k]));
      repeat (2) begin
        n = 0;
        do begin
          @(posedge clock);
          n++;
        end while (core_clk_tick !== 1'b1);
      end
      chk("div", n, 2 * (dv[k] == 0 ? 1 : dv[k]));
    end
    wr(8'h00, 16'h8000);
    band_gap_ready <= 1'b1;
    repeat (6) @(posedge clock);
    rd(8'h04, 16'h8000);
    mdl[4] = 16'h1;
    rd(8'h10, 16'h0);
    chk("irq", common_irq, 1'b1);
    wr(8'h00, 16'h4000);
    wr(8'h10, 16'h0001);
    mdl[4] = 16'h0;
    rd(8'h10, 16'h0);
    chk("irq", common_irq, 1'b0);
    wr(8'h0c, 16'h8000);
    band_gap_ready <= 1'b0;
    repeat (6) @(posedge clock);
    mdl[4] = 16'h2;
    rd(8'h10, 16'h0);
    rd(8'h04, 16'h4000);
    chk("irq", common_irq, 1'b1);
    wr(8'h0c, 16'h0);
    wr(8'h10, 16'h0002);
    mdl[4] = 16'h0;
    rd(8'h04, 16'h0);
    chk("irq", common_irq, 1'b0);
    wr(8'h00, 16'h0800);
    cores_busy <= 1'b1;
    wr(8'h08, 16'h1805);
    repeat (4) @(posedge clock);
    rd(8'h08, 16'h0);
    cores_busy <= 1'b0;
    seq_request <= 1'b1;
    n_ch = 0;
    n_cm = 0;
    n_sq = 0;
    wr(8'h08, 16'h1945);
    repeat (6) @(posedge clock);
    rd(8'h08, 16'h0400);
    chk("irq", common_irq, 1'b1);
    chk("blocked", n_ch + n_cm + n_sq, 0);
    wr(8'h08, 16'h0145);
    repeat (4) @(posedge clock);
    chk("chan", n_ch, 1);
    chk("comm", n_cm, 1);
    chk("seq", n_sq > 0, 1'b1);
    wr(8'h00, 16'h0000);
    @(posedge clock);
    n_sq = 0;
    repeat (4) @(posedge clock);
    chk("seq_off", n_sq, 0);
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
